// File: fault_port_dev.sv
// Purpose: Device end of the fault-report serial port.
// Assumes: Link logic runs on the shift clock and on select edges.
// Notes: Fault latch is quasi-static across the crossing.
// Behaviour
// - Valid frame needs multiple of 16 clocks
// - Frame error still re-enables flags from present faults
// - Full-duplex shifting, MSB first, host clocked
// - Output bit changes on falling clock
// - Host sets input before rising clock
// - Select fall: restart check, load, clear flag
// - Faults ignored while selected, caught after
// - Valid end: decode last word, enable flag
// - Valid end: clear latch, capture, flag faults
// - Error end: drop command, keep latch
// - Only real faults assert flag after error
// - Reset holds all gate outputs low
// - Reset defaults registers, clears faults, flags off
// - Reset release enables outputs and flags
// - Reset during power-down disables flags, gates
// - Clock idles low, select active low
// - Host waits one microsecond between frames
// - Chained words: last 16 bits command
// - Output word: four zeros, twelve fault bits
// - Input word: zero, address, six data
// - Four register addresses, bit 14 null
`timescale 1ns/100ps
`default_nettype none
module fault_port_dev (
    // System clock and power-on reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial link
    spi_link_if.dev link,
    // Present fault codes, two bits per channel
    input wire logic [fault_spi_pkg::FAULT_BITS-1:0] fault_in,
    // Gate drive and register contents
    output logic [fault_spi_pkg::CHANNELS-1:0] gate_drive_out,
    output logic [fault_spi_pkg::DATA_HI:0] dis_mode_out,
    output logic [fault_spi_pkg::DATA_HI:0] refresh_ref_out,
    output logic [fault_spi_pkg::DATA_HI:0] flag_mask_out,
    output logic [fault_spi_pkg::FAULT_BITS-1:0] fault_latch_out
);
    import fault_spi_pkg::*;

    typedef struct packed {
        logic [WORD_BITS-1:0] shift;
        logic [CNT_W-1:0] count;
        logic tag;
    } rx_state_s;

    typedef struct packed {
        logic [BIT_W-1:0] count;
        logic wrapped;
        logic fell;
        logic so;
    } tx_state_s;

    typedef struct packed {
        logic [WORD_BITS-1:0] cmd;
        logic ok;
        logic tag_seen;
        logic tog;
    } snap_state_s;

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic sel_prev;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic [FAULT_BITS-1:0] latch;
        logic flag_en;
        logic flag;
        logic status;
        logic [DATA_HI:0] gate_sel;
        logic [DATA_HI:0] dis_mode;
        logic [DATA_HI:0] refresh_ref;
        logic [DATA_HI:0] flag_mask;
        logic [CHANNELS-1:0] gate;
    } sys_state_s;

    rx_state_s rx_q, rx_d;
    tx_state_s tx_q, tx_d;
    snap_state_s snap_q, snap_d;
    sys_state_s sys_q, sys_d;
    logic started_q;
    logic [WORD_BITS-1:0] out_word;

    assign out_word = {OUT_PAD, sys_q.latch};

    // Frame-start marker, cleared whenever the device is deselected
    always_ff @(posedge link.sclk or posedge link.select_n)
    begin
        if (link.select_n)
            started_q <= 1'b0;
        else
            started_q <= 1'b1;
    end

    // Receive side: sample on the rising clock, count modulo a word
    always_comb
    begin
        rx_d = rx_q;
        rx_d.shift = {rx_q.shift[WORD_BITS-2:0], link.si};
        if (!started_q)
        begin
            rx_d.count = FIRST_BIT;
            rx_d.tag = ~rx_q.tag;
        end
        else if (rx_q.count == FULL_WORD)
            rx_d.count = FIRST_BIT;
        else
            rx_d.count = rx_q.count + FIRST_BIT;
    end

    always_ff @(posedge link.sclk or posedge reset)
    begin
        if (reset)
            rx_q <= '0;
        else
            rx_q <= rx_d;
    end

    // Transmit side: next bit on each falling clock; after one word
    // the received bits pass through, which serves a daisy chain
    always_comb
    begin
        tx_d = tx_q;
        tx_d.count = tx_q.count + 4'h1;
        tx_d.fell = 1'b1;
        tx_d.wrapped = tx_q.wrapped | (tx_q.count == LAST_BIT);
        if (tx_d.wrapped)
            tx_d.so = rx_q.shift[WORD_BITS-1];
        else
            tx_d.so = out_word[LAST_BIT - tx_d.count];
    end

    always_ff @(negedge link.sclk or posedge link.select_n)
    begin
        if (link.select_n)
            tx_q <= '0;
        else
            tx_q <= tx_d;
    end

    // First bit stands from the select fall, before any clock edge
    assign link.so_out = tx_q.fell ? tx_q.so : out_word[WORD_BITS-1];
    assign link.so_oe = ~link.select_n;

    // Frame end: judge the clock count and hold the last word.
    // Held values stay put for the next microsecond at least.
    always_comb
    begin
        snap_d = snap_q;
        snap_d.ok = (rx_q.tag != snap_q.tag_seen) && (rx_q.count == FULL_WORD);
        snap_d.tag_seen = rx_q.tag;
        snap_d.cmd = rx_q.shift;
        snap_d.tog = ~snap_q.tog;
    end

    always_ff @(posedge link.select_n or posedge reset)
    begin
        if (reset)
            snap_q <= '0;
        else
            snap_q <= snap_d;
    end

    // System side: flags, fault latch and command registers
    always_comb
    begin
        logic [CHANNELS-1:0] now_ch;
        logic [CHANNELS-1:0] held_ch;
        logic [FAULT_BITS-1:0] merged;
        logic cs_fall;
        logic frame_end;
        logic [1:0] addr;
        logic [DATA_HI:0] data;
        now_ch = '0;
        held_ch = '0;
        merged = sys_q.latch;
        sys_d = sys_q;
        sys_d.sel_s1 = link.select_n;
        sys_d.sel_s2 = sys_q.sel_s1;
        sys_d.sel_prev = sys_q.sel_s2;
        sys_d.tog_s1 = snap_q.tog;
        sys_d.tog_s2 = sys_q.tog_s1;
        cs_fall = sys_q.sel_prev & ~sys_q.sel_s2;
        frame_end = sys_q.tog_s2 != sys_q.tog_seen;
        addr = snap_q.cmd[ADDR_HI:ADDR_LO];
        data = snap_q.cmd[DATA_HI:0];
        // Keep an older fault type; fill empty channels only
        for (int c = 0; c < CHANNELS; c++)
        begin
            now_ch[c] = |fault_in[2*c +: 2];
            held_ch[c] = |sys_q.latch[2*c +: 2];
            if (!held_ch[c])
                merged[2*c +: 2] = fault_in[2*c +: 2];
        end
        if (frame_end)
        begin
            sys_d.tog_seen = sys_q.tog_s2;
            sys_d.flag_en = 1'b1;
            sys_d.flag = |(now_ch & ~sys_q.flag_mask);
            if (snap_q.ok)
            begin
                sys_d.latch = fault_in;
                if (!snap_q.cmd[CMD_ZERO_BIT] && !snap_q.cmd[CMD_NULL_BIT])
                begin
                    if (addr == ADDR_GATE_SEL)
                        sys_d.gate_sel = data;
                    else if (addr == ADDR_DIS_MODE)
                        sys_d.dis_mode = data;
                    else if (addr == ADDR_REFRESH_REF)
                        sys_d.refresh_ref = data;
                    else
                        sys_d.flag_mask = data;
                end
            end
            else
                sys_d.latch = merged;
        end
        else if (cs_fall)
        begin
            sys_d.flag_en = 1'b0;
            sys_d.flag = 1'b0;
        end
        else if (sys_q.sel_s2 && sys_q.flag_en)
        begin
            // Capture only while deselected
            sys_d.latch = merged;
            sys_d.flag = sys_q.flag | (|(now_ch & ~sys_q.flag_mask));
        end
        for (int c = 0; c < CHANNELS; c++)
            held_ch[c] = |sys_d.latch[2*c +: 2];
        sys_d.status = sys_d.flag_en & (|(held_ch & ~sys_d.flag_mask));
        sys_d.gate = sys_d.gate_sel & ~(sys_d.dis_mode & held_ch);
    end

    // Power-on reset: gates low, defaults, faults cleared, flags off
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sys_q <= '0;
            sys_q.sel_s1 <= 1'b1;
            sys_q.sel_s2 <= 1'b1;
            sys_q.sel_prev <= 1'b1;
            sys_q.flag_en <= 1'b1;
            sys_q.gate_sel <= GATE_SEL_RST;
            sys_q.dis_mode <= DIS_MODE_RST;
            sys_q.refresh_ref <= REFRESH_REF_RST;
            sys_q.flag_mask <= FLAG_MASK_RST;
        end
        else
            sys_q <= sys_d;
    end

    // Outputs straight from the state register
    assign link.fault_oe = sys_q.flag;
    assign link.status_oe = sys_q.status;
    assign gate_drive_out = sys_q.gate;
    assign dis_mode_out = sys_q.dis_mode;
    assign refresh_ref_out = sys_q.refresh_ref;
    assign flag_mask_out = sys_q.flag_mask;
    assign fault_latch_out = sys_q.latch;
endmodule // fault_port_dev
`default_nettype wire

// File: fault_spi_pkg.sv
// Purpose: Shared constants and types for the fault-report serial port.
// Assumes: 16-bit words, six channels with two fault bits each.
// Notes: Times are in ns; cycle counts derive from the system clock.
`default_nettype none
package fault_spi_pkg;
    // Word layout
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam int BIT_W = 4;
    localparam int CHANNELS = 6;
    localparam int FAULT_BITS = 12;
    localparam int CMD_ZERO_BIT = 15;
    localparam int CMD_NULL_BIT = 14;
    localparam int ADDR_HI = 13;
    localparam int ADDR_LO = 12;
    localparam int DATA_HI = 5;
    localparam logic [CNT_W-1:0] FULL_WORD = 5'h10;
    localparam logic [CNT_W-1:0] FIRST_BIT = 5'h01;
    localparam logic [BIT_W-1:0] LAST_BIT = 4'hf;
    localparam logic [3:0] OUT_PAD = 4'h0;
    // Register addresses
    localparam logic [1:0] ADDR_GATE_SEL = 2'h0;
    localparam logic [1:0] ADDR_DIS_MODE = 2'h1;
    localparam logic [1:0] ADDR_REFRESH_REF = 2'h2;
    localparam logic [1:0] ADDR_FLAG_MASK = 2'h3;
    // Register defaults
    localparam logic [DATA_HI:0] GATE_SEL_RST = 6'h00;
    localparam logic [DATA_HI:0] DIS_MODE_RST = 6'h00;
    localparam logic [DATA_HI:0] REFRESH_REF_RST = 6'h00;
    localparam logic [DATA_HI:0] FLAG_MASK_RST = 6'h00;
    // Timing
    localparam int CLK_NS = 8;
    localparam int SETUP_NS = 60;
    localparam int HOLD_NS = 75;
    localparam int GAP_NS = 1000;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_W = 8;
    localparam logic [1:0] PHASE_RISE = 2'h1;
    localparam logic [1:0] PHASE_FALL = 2'h3;
    // Host sequencer states
    typedef enum logic [4:0] {
        H_IDLE = 5'b0_0001,
        H_LEAD = 5'b0_0010,
        H_SHIFT = 5'b0_0100,
        H_TRAIL = 5'b0_1000,
        H_GAP = 5'b1_0000
    } host_state_e;
endpackage
`default_nettype wire

// File: spi_link_if.sv
// Purpose: Wires between host and device ends of the serial port.
// Assumes: Pull-ups on select and flags, release of the data line.
// Notes: Pin levels are resolved here from the drive enables.
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
    // Host driven pins
    logic select_n;
    logic sclk;
    logic si;
    // Device drive signals
    logic so_out;
    logic so_oe;
    logic fault_oe;
    logic status_oe;
    // Resolved pin levels
    wire so;
    wire fault_flag_n;
    wire status_flag_n;

    // Open-drain flags with pull-ups; a released data line shows the
    // inverse of the top answer bit, so nothing may lean on a floating level
    assign so = so_oe ? so_out : ~so_out;
    assign fault_flag_n = fault_oe ? 1'b0 : 1'b1;
    assign status_flag_n = status_oe ? 1'b0 : 1'b1;

    modport dev (input select_n, input sclk, input si,
                 output so_out, output so_oe, output fault_oe, output status_oe);
    modport host (output select_n, output sclk, output si,
                  input so, input fault_flag_n, input status_flag_n);
endinterface
`default_nettype wire

// File: fault_port_host.sv
// Purpose: Host end: sends one command frame, returns the answer.
// Assumes: Shift clock made here at a quarter of the system clock.
// Notes: Clock count per frame is set per request for error tests.
`timescale 1ns/100ps
`default_nettype none
module fault_port_host (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial link
    spi_link_if.host link,
    // Command request
    input wire logic cmd_valid,
    input wire logic [fault_spi_pkg::WORD_BITS-1:0] cmd_word,
    input wire logic [fault_spi_pkg::CNT_W-1:0] cmd_clocks,
    output logic cmd_ready,
    // Answer and flags
    output logic rsp_valid,
    output logic [fault_spi_pkg::WORD_BITS-1:0] rsp_word,
    output logic fault_seen,
    output logic status_seen
);
    import fault_spi_pkg::*;

    typedef struct packed {
        host_state_e state;
        logic sel_n;
        logic sclk;
        logic mosi;
        logic [1:0] phase;
        logic [CNT_W-1:0] left;
        logic [WAIT_W-1:0] wait_cnt;
        logic [WORD_BITS-1:0] tx;
        logic [WORD_BITS-1:0] rx;
        logic ready;
        logic rsp_valid;
        logic [WORD_BITS-1:0] rsp;
        logic so_s1;
        logic so_s2;
        logic flt_s1;
        logic flt_s2;
        logic sta_s1;
        logic sta_s2;
    } host_state_s;

    host_state_s h_q, h_d;

    // Sequencer: select, clock pairs, hold, then the frame gap
    always_comb
    begin
        h_d = h_q;
        h_d.rsp_valid = 1'b0;
        h_d.so_s1 = link.so;
        h_d.so_s2 = h_q.so_s1;
        h_d.flt_s1 = link.fault_flag_n;
        h_d.flt_s2 = h_q.flt_s1;
        h_d.sta_s1 = link.status_flag_n;
        h_d.sta_s2 = h_q.sta_s1;
        case (h_q.state)
            H_IDLE:
            begin
                if (cmd_valid)
                begin
                    h_d.ready = 1'b0;
                    h_d.sel_n = 1'b0;
                    h_d.tx = cmd_word;
                    h_d.mosi = cmd_word[WORD_BITS-1];
                    h_d.left = cmd_clocks;
                    h_d.rx = '0;
                    h_d.wait_cnt = WAIT_W'(SETUP_CYC);
                    h_d.state = H_LEAD;
                end
            end
            H_LEAD:
            begin
                h_d.wait_cnt = h_q.wait_cnt - 8'h01;
                h_d.phase = '0;
                if (h_q.wait_cnt == '0)
                    h_d.state = (h_q.left == '0) ? H_TRAIL : H_SHIFT;
                h_d.wait_cnt = (h_q.wait_cnt == '0) ? WAIT_W'(HOLD_CYC) : h_d.wait_cnt;
            end
            H_SHIFT:
            begin
                h_d.phase = h_q.phase + 2'h1;
                if (h_q.phase == PHASE_RISE)
                    h_d.sclk = 1'b1;
                else if (h_q.phase == PHASE_FALL)
                begin
                    // Synced line holds the bit set at the last fall
                    h_d.sclk = 1'b0;
                    h_d.rx = {h_q.rx[WORD_BITS-2:0], h_q.so_s2};
                    h_d.tx = {h_q.tx[WORD_BITS-2:0], 1'b0};
                    h_d.mosi = h_q.tx[WORD_BITS-2];
                    h_d.left = h_q.left - FIRST_BIT;
                    if (h_q.left == FIRST_BIT)
                        h_d.state = H_TRAIL;
                end
            end
            H_TRAIL:
            begin
                h_d.wait_cnt = h_q.wait_cnt - 8'h01;
                if (h_q.wait_cnt == '0)
                begin
                    h_d.sel_n = 1'b1;
                    h_d.mosi = 1'b0;
                    h_d.rsp_valid = 1'b1;
                    h_d.rsp = h_q.rx;
                    h_d.wait_cnt = WAIT_W'(GAP_CYC);
                    h_d.state = H_GAP;
                end
            end
            H_GAP:
            begin
                // Keeps the deselect time between frames
                h_d.wait_cnt = h_q.wait_cnt - 8'h01;
                if (h_q.wait_cnt == '0)
                begin
                    h_d.ready = 1'b1;
                    h_d.state = H_IDLE;
                end
            end
            default:
                h_d.state = H_IDLE;
        endcase
    end

    // Idle: deselected, clock low, ready
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            h_q <= '0;
            h_q.state <= H_IDLE;
            h_q.sel_n <= 1'b1;
            h_q.ready <= 1'b1;
            h_q.flt_s1 <= 1'b1;
            h_q.flt_s2 <= 1'b1;
            h_q.sta_s1 <= 1'b1;
            h_q.sta_s2 <= 1'b1;
        end
        else
            h_q <= h_d;
    end

    assign link.select_n = h_q.sel_n;
    assign link.sclk = h_q.sclk;
    assign link.si = h_q.mosi;
    assign cmd_ready = h_q.ready;
    assign rsp_valid = h_q.rsp_valid;
    assign rsp_word = h_q.rsp;
    assign fault_seen = ~h_q.flt_s2;
    assign status_seen = ~h_q.sta_s2;
endmodule // fault_port_host
`default_nettype wire

// File: spi_fault_report_frame_check_props.sv
// Purpose: Watches the serial link between the host and device ends.
// Assumes: Shift clock is derived from clk_sys, so it is sampled on clk_sys.
// Notes: Gap counter saturates, so long idle periods never wrap.
`timescale 1ns/100ps
`default_nettype none
module spi_fault_report_frame_check_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Host driven pins
    input wire logic select_n,
    input wire logic sclk,
    input wire logic si,
    // Device drive signals and resolved pins
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic fault_oe,
    input wire logic status_oe,
    input wire logic so,
    input wire logic fault_flag_n,
    input wire logic status_flag_n
);
    import fault_spi_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Deselected cycles since select rose; starts full so the first frame passes
    logic [7:0] gap_q;
    always_ff @(posedge clk_sys)
        if (reset)
            gap_q <= 8'hff;
        else if (!select_n)
            gap_q <= 8'h00;
        else if (gap_q != 8'hff)
            gap_q <= gap_q + 8'h01;

    // Frame start, then a quiet lead with the top answer bit on the line
    sequence frame_open;
        $fell(select_n);
    endsequence
    sequence lead_quiet;
        (!sclk && !so_out) [*8];
    endsequence

    a_so_release: assert property (so_oe == !select_n)
        else $error("data output enable disagrees with select");
    a_so_drive: assert property (so_oe |-> so == so_out)
        else $error("data line does not carry the driven bit");
    a_lead_bit: assert property (frame_open |-> lead_quiet)
        else $error("lead phase not quiet or top answer bit set");
    a_so_fall_only: assert property ((sclk && $past(sclk)) |-> $stable(so_out))
        else $error("data output moved while shift clock high");
    a_si_steady: assert property ((sclk && $past(sclk)) |-> $stable(si))
        else $error("serial input moved while shift clock high");
    a_sclk_idle: assert property (select_n |-> !sclk)
        else $error("shift clock high while deselected");
    a_flag_quiet: assert property ((!select_n && $past(!select_n, 5)) |-> fault_flag_n)
        else $error("fault flag active during a frame");
    a_gap_min: assert property (frame_open |-> gap_q >= GAP_CYC)
        else $error("frames closer than the minimum gap");
    a_reset_flags: assert property ($past(reset) |-> fault_flag_n && status_flag_n)
        else $error("flags active right after reset");
    a_flag_pins: assert property (fault_flag_n == !fault_oe && status_flag_n == !status_oe)
        else $error("flag pins disagree with their drives");
    c_frame: cover property (frame_open);
endmodule // spi_fault_report_frame_check_props
`default_nettype wire

// File: spi_fault_report_frame_check_tb.sv
// Purpose: Self-checking bench joining host and device ends over the link.
// Assumes: Answers are judged in order by a monitor fed from a queue.
// Notes: Frame error cases reuse one loop over bad clock counts.
`timescale 1ns/100ps
`default_nettype none
module spi_fault_report_frame_check_tb;
    import fault_spi_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b0;
    logic cmd_valid = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic [4:0] cmd_clocks = 5'h10;
    logic [11:0] fault_in = 12'h000;
    logic cmd_ready, rsp_valid, fault_seen, status_seen;
    logic [15:0] rsp_word;
    logic [5:0] gate_drive_out, dis_mode_out, refresh_ref_out, flag_mask_out, d, dm, got;
    logic [11:0] fault_latch_out, lat;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [4:0] bad [4] = '{5'h00, 5'h0f, 5'h11, 5'h1f};
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h28bb;
    int i;

    // System clock
    always #4 clk_sys = ~clk_sys;

    spi_link_if link();
    fault_port_host u_fault_port_host (.clk_sys(clk_sys), .reset(reset), .link(link),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_clocks(cmd_clocks),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
        .fault_seen(fault_seen), .status_seen(status_seen));
    fault_port_dev u_fault_port_dev (.clk_sys(clk_sys), .reset(reset), .link(link),
        .fault_in(fault_in), .gate_drive_out(gate_drive_out), .dis_mode_out(dis_mode_out),
        .refresh_ref_out(refresh_ref_out), .flag_mask_out(flag_mask_out),
        .fault_latch_out(fault_latch_out));
    spi_fault_report_frame_check_props u_spi_fault_report_frame_check_props (
        .clk_sys(clk_sys), .reset(reset), .select_n(link.select_n), .sclk(link.sclk),
        .si(link.si), .so_out(link.so_out), .so_oe(link.so_oe), .fault_oe(link.fault_oe),
        .status_oe(link.status_oe), .so(link.so), .fault_flag_n(link.fault_flag_n),
        .status_flag_n(link.status_flag_n));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Inputs always move one ns after the edge
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One frame; the answer seen depends on how many clocks were sent
    task frame(input logic [15:0] w, input logic [4:0] n, input logic [15:0] ans);
        int k;
        case (n)
            5'h10: exp_q.push_back({16'hffff, ans});
            5'h0f: exp_q.push_back({16'h7fff, 1'b0, ans[15:1]});
            5'h11: exp_q.push_back({16'hffff, ans[14:0], w[15]});
            5'h1f: exp_q.push_back({16'hffff, ans[0], w[15:1]});
            5'h00: exp_q.push_back({16'hffff, 16'h0000});
            default: exp_q.push_back(32'h0000_0000);
        endcase
        cmd_word = w;
        cmd_clocks = n;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        for (k = 0; k < 400 && cmd_ready !== 1'b1; k++)
            tick(1);
        if (cmd_ready !== 1'b1)
        begin
            $display("[FAIL] %0t: host never returned to idle", $time);
            fail_count++;
            test_done();
        end
    endtask

    // Each answer is compared with the oldest note, mid-cycle where it has settled
    always @(negedge clk_sys)
        if (rsp_valid === 1'b1)
        begin
            e = exp_q.pop_front();
            check(rsp_word & e[31:16], e[15:0]);
        end

    initial
    begin
        // A real rising edge, so the link-side flops clear as well
        #1;
        reset = 1'b1;
        tick(12);
        reset = 1'b0;
        check({4'h0, gate_drive_out, dis_mode_out}, 16'h0000);
        check({4'h0, refresh_ref_out, flag_mask_out}, 16'h0000);
        tick(4);
        frame(16'h403f, 5'h10, 16'h0000);
        check({4'h0, gate_drive_out, dis_mode_out}, 16'h0000);
        lat = 12'($random(seed)) | 12'h001;
        fault_in = lat;
        tick(20);
        check({4'h0, fault_latch_out}, {4'h0, lat});
        check({14'h0, fault_seen, status_seen}, 16'h0003);
        fault_in = 12'h000;
        // Short, long and empty frames must all be dropped
        for (i = 0; i < 4; i++)
        begin
            frame(16'h003f, bad[i], {4'h0, lat});
            check({4'h0, fault_latch_out}, {4'h0, lat});
            check({4'h0, gate_drive_out, fault_seen, 4'h0, status_seen}, 16'h0001);
        end
        fault_in = lat;
        frame(16'h003f, 5'h11, {4'h0, lat});
        check({15'h0, fault_seen}, 16'h0001);
        fault_in = 12'h000;
        frame(16'h3000, 5'h10, {4'h0, lat});
        check({4'h0, fault_latch_out}, 16'h0000);
        check({14'h0, fault_seen, status_seen}, 16'h0000);
        // Every register address with random data
        for (i = 0; i < 4; i++)
        begin
            d = 6'($random(seed));
            frame({2'b00, 2'(i), 6'h00, d}, 5'h10, 16'h0000);
            case (i)
                0: got = gate_drive_out;
                1: got = dis_mode_out;
                2: got = refresh_ref_out;
                default: got = flag_mask_out;
            endcase
            if (i == 1)
                dm = d;
            check({10'h0, got}, {10'h0, d});
        end
        frame({4'h9, 6'h00, ~dm}, 5'h10, 16'h0000);
        check({10'h0, dis_mode_out}, {10'h0, dm});
        reset = 1'b1;
        tick(4);
        reset = 1'b0;
        check({4'h0, gate_drive_out, dis_mode_out}, 16'h0000);
        check({4'h0, refresh_ref_out, flag_mask_out}, 16'h0000);
        tick(4);
        frame(16'h002a, 5'h10, 16'h0000);
        check({10'h0, gate_drive_out}, 16'h002a);
        check(16'(exp_q.size()), 16'h0000);
        test_done();
    end
endmodule // spi_fault_report_frame_check_tb
`default_nettype wire
